// File: hw/fsb_req_defines.svh
// constants for the system bus request-phase block
// assumes nothing else defines the FSB_ prefix
`ifndef FSB_REQ_DEFINES_SVH
`define FSB_REQ_DEFINES_SVH

`define FSB_SPACE_BITS 36
`define FSB_ADDR_LSB 3
`define FSB_ADDR_W 33
`define FSB_A20_IDX 17
`define FSB_RTYPE_W 5
`define FSB_STB_W 2
`define FSB_SYNC_W 44
`define FSB_HIST_W 3
`define FSB_ADS_MIN_CYC 3
`define FSB_ST_IDLE 3'h1
`define FSB_ST_SUB1 3'h2
`define FSB_ST_SUB2 3'h4
`define FSB_STB_ASSERT 2'h0
`define FSB_STB_IDLE 2'h3

`endif

// File: hw/fsb_req_pkg.sv
// types shared by the request-phase block and its bench
// assumes fsb_req_defines.svh is on the include path
`include "fsb_req_defines.svh"

package fsb_req_pkg;

    typedef logic [`FSB_ADDR_W-1:0] addr_t;
    typedef logic [`FSB_RTYPE_W-1:0] rtype_t;

    // one request: sub-phase 1 address, sub-phase 2 type info
    typedef struct packed {
        addr_t addr;
        addr_t attr;
        rtype_t rtype;
    } req_s;

    // a transaction seen on the bus from another agent
    typedef struct packed {
        logic valid;
        addr_t addr;
        addr_t attr;
        rtype_t rtype;
    } obs_s;

    typedef enum logic [2:0] {
        ST_IDLE = `FSB_ST_IDLE,
        ST_SUB1 = `FSB_ST_SUB1,
        ST_SUB2 = `FSB_ST_SUB2
    } issue_state_e;

endpackage

// File: hw/fsb_sync2.sv
// two-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level; no bus coherence is promised
`timescale 1ns/100ps
`default_nettype none

module fsb_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // resets to all ones: every bus pin idles high (deasserted)
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta <= '1;
            q <= '1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

`default_nettype wire

// File: hw/system_bus_request_phase.sv
// request phase of a shared system bus, processor side
// assumes mclk (20 MHz) is much faster than the sampled bus clock
`include "fsb_req_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module system_bus_request_phase (
    input wire logic mclk,
    input wire logic rst_n,
    // bus clock leg 0, sampled as an ordinary input
    input wire logic bus_clk,
    // address lines, bits 35..3
    input wire logic [`FSB_ADDR_W-1:0] addr_n_in,
    output logic [`FSB_ADDR_W-1:0] addr_n_out,
    output logic addr_oe,
    input wire logic [`FSB_STB_W-1:0] address_source_strobes_n_in,
    output logic [`FSB_STB_W-1:0] address_source_strobes_n_out,
    output logic address_source_strobes_oe,
    input wire logic address_valid_strobe_n_in,
    output logic address_valid_strobe_n_out,
    output logic address_valid_strobe_oe,
    input wire logic [`FSB_RTYPE_W-1:0] rtype_n_in,
    output logic [`FSB_RTYPE_W-1:0] rtype_n_out,
    output logic rtype_oe,
    input wire logic block_next_request_n_in,
    output logic block_next_request_n_out,
    output logic block_next_request_oe,
    input wire logic address_bit20_mask_n,
    // core side
    input wire logic req_valid,
    input wire fsb_req_pkg::req_s req,
    output logic req_taken,
    output fsb_req_pkg::addr_t lookup_addr,
    input wire logic local_busy,
    output fsb_req_pkg::obs_s obs,
    output fsb_req_pkg::addr_t straps
);

    // every pin input passes two flops before use
    logic [`FSB_SYNC_W-1:0] pins_raw;
    logic [`FSB_SYNC_W-1:0] pins;

    assign pins_raw = {bus_clk, addr_n_in, address_source_strobes_n_in,
                       address_valid_strobe_n_in, block_next_request_n_in,
                       rtype_n_in, address_bit20_mask_n};

    fsb_sync2 #(
        .W(`FSB_SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d(pins_raw),
        .q(pins)
    );

    wire logic bclk_s;
    wire fsb_req_pkg::addr_t addr_n_s;
    wire logic [`FSB_STB_W-1:0] stb_n_s;
    wire logic ads_n_s;
    wire logic bnr_n_s;
    wire fsb_req_pkg::rtype_t rtype_n_s;
    wire logic address_bit20_mask_n_s;

    assign {bclk_s, addr_n_s, stb_n_s, ads_n_s, bnr_n_s, rtype_n_s,
            address_bit20_mask_n_s} = pins;

    // bus clock edge detection
    logic bclk_d;
    wire logic bclk_rise;
    wire logic bclk_fall;

    // resets high to match the synchroniser, so no false rise after reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bclk_d <= 1'b1;
        end else begin
            bclk_d <= bclk_s;
        end
    end

    assign bclk_rise = bclk_s && !bclk_d;
    assign bclk_fall = !bclk_s && bclk_d;

    // decoded active-low inputs
    wire logic stall;
    wire logic address_bit20_mask;
    wire logic ads_seen;
    wire logic stb_asserted;

    assign stall = !bnr_n_s;
    assign address_bit20_mask = !address_bit20_mask_n_s;
    assign ads_seen = !ads_n_s;
    assign stb_asserted = !stb_n_s[0];

    // straps: own unreset synchroniser, as the shared one holds all ones
    // in reset; tracked throughout reset, frozen at release
    logic [`FSB_ADDR_W-1:0] strap_meta, strap_sync;
    always_ff @(posedge mclk) begin
        strap_meta <= addr_n_in;
        strap_sync <= strap_meta;
        if (!rst_n) begin
            straps <= ~strap_sync;
        end
    end

    // stall drive: registered, so the pin changes one cycle after busy
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            block_next_request_n_out <= 1'b1;
            block_next_request_oe <= 1'b0;
        end else begin
            block_next_request_n_out <= !local_busy;
            block_next_request_oe <= local_busy;
        end
    end

    // issue path
    fsb_req_pkg::issue_state_e state;
    fsb_req_pkg::issue_state_e next_state;
    wire logic issue;
    wire logic to_sub2;
    wire logic to_idle;
    wire fsb_req_pkg::addr_t masked_addr;

    // mask bit 20 before lookup and drive; the mask is only sampled at
    // issue, so a mask change mid-transaction has no effect on it
    assign masked_addr = address_bit20_mask ?
        (req.addr & ~(`FSB_ADDR_W'(1) << `FSB_A20_IDX)) : req.addr;

    // issue only at a bus clock rise and never under a stall
    assign issue = (state == fsb_req_pkg::ST_IDLE) && req_valid &&
                   !stall && bclk_rise;
    assign to_sub2 = (state == fsb_req_pkg::ST_SUB1) && bclk_fall;
    assign to_idle = (state == fsb_req_pkg::ST_SUB2) && bclk_rise;

    always_comb begin
        next_state = state;
        case (state)
            fsb_req_pkg::ST_IDLE: begin
                if (issue) begin
                    next_state = fsb_req_pkg::ST_SUB1;
                end
            end
            fsb_req_pkg::ST_SUB1: begin
                if (to_sub2) begin
                    next_state = fsb_req_pkg::ST_SUB2;
                end
            end
            fsb_req_pkg::ST_SUB2: begin
                if (to_idle) begin
                    next_state = fsb_req_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = fsb_req_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= fsb_req_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    fsb_req_pkg::addr_t attr_hold;
    logic drive;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            attr_hold <= '0;
            lookup_addr <= '0;
            req_taken <= 1'b0;
        end else begin
            req_taken <= issue;
            if (issue) begin
                attr_hold <= req.attr;
                lookup_addr <= masked_addr;
            end
        end
    end

    // pin drive, all active low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            drive <= 1'b0;
            addr_n_out <= '1;
            rtype_n_out <= '1;
            address_valid_strobe_n_out <= 1'b1;
            address_source_strobes_n_out <= `FSB_STB_IDLE;
        end else if (issue) begin
            drive <= 1'b1;
            addr_n_out <= ~masked_addr;
            rtype_n_out <= ~req.rtype;
            address_valid_strobe_n_out <= 1'b0;
            address_source_strobes_n_out <= `FSB_STB_ASSERT;
        end else if (to_sub2) begin
            addr_n_out <= ~attr_hold;
            address_source_strobes_n_out <= `FSB_STB_IDLE;
        end else if (to_idle) begin
            drive <= 1'b0;
            addr_n_out <= '1;
            rtype_n_out <= '1;
            address_valid_strobe_n_out <= 1'b1;
        end
    end

    assign addr_oe = drive;
    assign rtype_oe = drive;
    assign address_valid_strobe_oe = drive;
    assign address_source_strobes_oe = drive;

    // own drive echoes back through the synchroniser; ignore it a while
    logic [`FSB_HIST_W-1:0] drive_hist;
    wire logic self;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            drive_hist <= '0;
        end else begin
            drive_hist <= {drive_hist[`FSB_HIST_W-2:0], drive};
        end
    end

    assign self = drive || (|drive_hist);

    // receive path: address on strobe fall, type info on strobe rise
    logic stb_d;
    logic rx_open;
    wire logic stb_fall;
    wire logic stb_rise;

    assign stb_fall = stb_asserted && !stb_d;
    assign stb_rise = !stb_asserted && stb_d;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stb_d <= 1'b0;
            rx_open <= 1'b0;
            obs <= '0;
        end else begin
            stb_d <= stb_asserted;
            obs.valid <= 1'b0;
            if (stb_fall && ads_seen && !self) begin
                rx_open <= 1'b1;
                obs.addr <= ~addr_n_s;
                obs.rtype <= ~rtype_n_s;
            end else if (stb_rise && rx_open) begin
                rx_open <= 1'b0;
                obs.attr <= ~addr_n_s;
                obs.valid <= 1'b1;
            end
        end
    end

    // checks
    property p_no_issue_in_stall;
        @(posedge mclk) disable iff (!rst_n)
        $rose(address_valid_strobe_oe) |-> !$past(stall);
    endproperty
    a_no_issue_in_stall: assert property (p_no_issue_in_stall)
        else $error("transaction issued during a bus stall");

    property p_issue_on_rise;
        @(posedge mclk) disable iff (!rst_n)
        $rose(address_valid_strobe_oe) |-> $past(bclk_rise);
    endproperty
    a_issue_on_rise: assert property (p_issue_on_rise)
        else $error("transaction not launched at a bus clock rise");

    property p_a20_masked;
        @(posedge mclk) disable iff (!rst_n)
        ($rose(addr_oe) && $past(address_bit20_mask)) |->
            addr_n_out[`FSB_A20_IDX] && !lookup_addr[`FSB_A20_IDX];
    endproperty
    a_a20_masked: assert property (p_a20_masked)
        else $error("address bit 20 not masked");

    property p_subphases;
        @(posedge mclk) disable iff (!rst_n)
        $rose(addr_oe) |-> (address_source_strobes_n_out == `FSB_STB_ASSERT)
            ##[1:20] (address_source_strobes_n_out == `FSB_STB_IDLE &&
                      addr_n_out == ~attr_hold && addr_oe);
    endproperty
    a_subphases: assert property (p_subphases)
        else $error("second sub-phase missing or out of order");

    property p_ads_width;
        @(posedge mclk) disable iff (!rst_n)
        $rose(address_valid_strobe_oe) |->
            (address_valid_strobe_oe && !address_valid_strobe_n_out)[*3];
    endproperty
    a_ads_width: assert property (p_ads_width)
        else $error("address-valid strobe too short");

    property p_active_low;
        @(posedge mclk) disable iff (!rst_n)
        address_valid_strobe_oe |-> !address_valid_strobe_n_out;
    endproperty
    a_active_low: assert property (p_active_low)
        else $error("address-valid strobe driven high");

    property p_bnr_follows_busy;
        @(posedge mclk) disable iff (!rst_n)
        local_busy |=> (block_next_request_oe && !block_next_request_n_out);
    endproperty
    a_bnr_follows_busy: assert property (p_bnr_follows_busy)
        else $error("busy agent did not stall the bus");

    property p_straps_frozen;
        @(posedge mclk) disable iff (!rst_n)
        $past(rst_n) |-> $stable(straps);
    endproperty
    a_straps_frozen: assert property (p_straps_frozen)
        else $error("straps changed after reset release");

    property p_obs_pulse;
        @(posedge mclk) disable iff (!rst_n)
        obs.valid |-> !$past(obs.valid) && $past(rx_open) ##1 !obs.valid;
    endproperty
    a_obs_pulse: assert property (p_obs_pulse)
        else $error("observed transaction pulse malformed");

    c_issue: cover property (@(posedge mclk) disable iff (!rst_n)
        req_taken ##[1:30] (state == fsb_req_pkg::ST_IDLE));
    c_masked: cover property (@(posedge mclk) disable iff (!rst_n)
        req_taken && address_bit20_mask);
    c_observed: cover property (@(posedge mclk) disable iff (!rst_n)
        obs.valid);
    c_stall_wait: cover property (@(posedge mclk) disable iff (!rst_n)
        (req_valid && stall) ##1 req_valid [*2] ##[1:40] req_taken);

endmodule

`default_nettype wire

// File: test/bus_agent_model.sv
// far-side bus agent: free bus clock, stall, foreign requests, issue capture
// assumes lines are terminated high, so a released line reads deasserted
`include "fsb_req_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module bus_agent_model (
    input wire logic mclk,
    output var logic bus_clk,
    output var fsb_req_pkg::addr_t addr_drv_n,
    output var logic [`FSB_STB_W-1:0] stb_drv_n,
    output var logic ads_drv_n,
    output var fsb_req_pkg::rtype_t rtype_drv_n,
    output var logic bnr_drv_n,
    input wire logic bnr_w,
    input wire fsb_req_pkg::addr_t addr_n_out,
    input wire logic addr_oe,
    input wire logic [`FSB_STB_W-1:0] stb_n_out,
    input wire logic ads_n_out,
    input wire fsb_req_pkg::rtype_t rtype_n_out,
    output var logic seen,
    output var fsb_req_pkg::req_s seen_req
);
    logic oe_d = 1'b0;

    initial begin
        {addr_drv_n, stb_drv_n, ads_drv_n, rtype_drv_n, bnr_drv_n} = '1;
        seen = 1'b0;
        seen_req = '0;
        bus_clk = 1'b0;
        #13;
        forever #200 bus_clk = ~bus_clk;
    end

    // issue capture: sub-phase 1 address under strobes, sub-phase 2 type
    always @(posedge mclk) begin
        seen <= oe_d && !addr_oe;
        oe_d <= addr_oe;
        if (addr_oe && !ads_n_out && stb_n_out == `FSB_STB_ASSERT) begin
            seen_req.addr <= ~addr_n_out;
            seen_req.rtype <= ~rtype_n_out;
        end
        if (addr_oe && stb_n_out == `FSB_STB_IDLE)
            seen_req.attr <= ~addr_n_out;
    end

    task automatic stall(input logic on);
        bnr_drv_n <= ~on;
    endtask

    task automatic strap(input fsb_req_pkg::addr_t v);
        addr_drv_n <= ~v;
    endtask

    // lines held 6 cycles each side of the strobe so a sampler can settle
    task automatic send(input fsb_req_pkg::req_s r);
        while (bnr_w !== 1'b1) @(posedge mclk);
        ads_drv_n <= 1'b0;
        addr_drv_n <= ~r.addr;
        rtype_drv_n <= ~r.rtype;
        stb_drv_n <= `FSB_STB_ASSERT;
        repeat (6) @(posedge mclk);
        addr_drv_n <= ~r.attr;
        stb_drv_n <= `FSB_STB_IDLE;
        repeat (6) @(posedge mclk);
        ads_drv_n <= 1'b1;
        addr_drv_n <= '1;
        rtype_drv_n <= '1;
    endtask
endmodule

`default_nettype wire

// File: test/system_bus_request_phase_tb_top.sv
// bench for the request-phase block against the far-side agent model
// assumes the wire level is the and of every driver, released lines high
`include "fsb_req_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module system_bus_request_phase_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic local_busy = 1'b0;
    logic mask_n = 1'b1;
    fsb_req_pkg::req_s req = '0;
    fsb_req_pkg::req_s q_iss[$];
    fsb_req_pkg::obs_s q_obs[$];
    fsb_req_pkg::req_s r;
    fsb_req_pkg::addr_t strap_v;
    logic [15:0] seed = 16'h000f;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    wire logic bus_clk, ads_o, ads_oe, bnr_o, bnr_oe, seen, taken;
    wire logic addr_oe, stb_oe, rt_oe, m_ads, m_bnr;
    wire fsb_req_pkg::addr_t a_o, m_a, lookup, straps;
    wire fsb_req_pkg::rtype_t rt_o, m_rt;
    wire logic [`FSB_STB_W-1:0] stb_o, m_stb;
    wire fsb_req_pkg::req_s seen_req;
    wire fsb_req_pkg::obs_s obs;
    wire fsb_req_pkg::addr_t a_w = (addr_oe ? a_o : '1) & m_a;
    wire logic [`FSB_STB_W-1:0] stb_w = (stb_oe ? stb_o : '1) & m_stb;
    wire logic ads_w = (ads_oe ? ads_o : 1'b1) & m_ads;
    wire fsb_req_pkg::rtype_t rt_w = (rt_oe ? rt_o : '1) & m_rt;
    wire logic bnr_w = (bnr_oe ? bnr_o : 1'b1) & m_bnr;

    initial forever #25 mclk = ~mclk;

    system_bus_request_phase u_system_bus_request_phase (
        .mclk(mclk), .rst_n(rst_n), .bus_clk(bus_clk),
        .addr_n_in(a_w), .addr_n_out(a_o), .addr_oe(addr_oe),
        .address_source_strobes_n_in(stb_w),
        .address_source_strobes_n_out(stb_o),
        .address_source_strobes_oe(stb_oe),
        .address_valid_strobe_n_in(ads_w),
        .address_valid_strobe_n_out(ads_o),
        .address_valid_strobe_oe(ads_oe),
        .rtype_n_in(rt_w), .rtype_n_out(rt_o), .rtype_oe(rt_oe),
        .block_next_request_n_in(bnr_w), .block_next_request_n_out(bnr_o),
        .block_next_request_oe(bnr_oe), .address_bit20_mask_n(mask_n),
        .req_valid(req_valid), .req(req), .req_taken(taken),
        .lookup_addr(lookup), .local_busy(local_busy), .obs(obs),
        .straps(straps));

    bus_agent_model u_bus_agent_model (
        .mclk(mclk), .bus_clk(bus_clk), .addr_drv_n(m_a),
        .stb_drv_n(m_stb), .ads_drv_n(m_ads), .rtype_drv_n(m_rt),
        .bnr_drv_n(m_bnr), .bnr_w(bnr_w), .addr_n_out(a_o),
        .addr_oe(addr_oe), .stb_n_out(stb_o), .ads_n_out(ads_o),
        .rtype_n_out(rt_o), .seen(seen), .seen_req(seen_req));

    task automatic test_done();
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [71:0] got,
                         input logic [71:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic new_req(output fsb_req_pkg::req_s v);
        seed = lfsr(seed);
        v.addr[15:0] = seed;
        seed = lfsr(seed);
        v.addr[32:16] = {seed[0], seed};
        seed = lfsr(seed);
        v.attr = {seed[0], seed, ~seed};
        v.rtype = seed[5:1];
        v.addr[`FSB_A20_IDX] = 1'b1;
    endtask

    // kind 0 free bus, 1 far agent stalls, 2 own block busy
    task automatic issue(input fsb_req_pkg::req_s v, input logic mask,
                         input int kind);
        fsb_req_pkg::req_s e;
        int n;
        e = v;
        if (mask) e.addr[`FSB_A20_IDX] = 1'b0;
        q_iss.push_back(e);
        mask_n <= ~mask;
        if (kind == 1) u_bus_agent_model.stall(1'b1);
        if (kind == 2) local_busy <= 1'b1;
        repeat (4) @(posedge mclk);
        if (kind == 2) check("bnr", 72'({bnr_oe, bnr_o}), 72'h2);
        req <= v;
        req_valid <= 1'b1;
        if (kind != 0) begin
            // 20 cycles span more than one bus clock rise
            repeat (20) begin
                @(posedge mclk);
                check("taken in stall", 72'(taken), 72'h0);
            end
            u_bus_agent_model.stall(1'b0);
            local_busy <= 1'b0;
        end
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (taken !== 1'b1 && n < 200);
        req_valid <= 1'b0;
        check("lookup", 72'(lookup), 72'(e.addr));
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((q_iss.size() + q_obs.size()) != 0 && n < 500) begin
            @(posedge mclk);
            n++;
        end
        check("pending", 72'(q_iss.size() + q_obs.size()), 72'h0);
        repeat (8) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
        if (seen === 1'b1) begin
            if (q_iss.size() == 0) check("issue extra", 72'h1, 72'h0);
            else check("issued", 72'(seen_req), 72'(q_iss.pop_front()));
        end
        if (obs.valid === 1'b1) begin
            if (q_obs.size() == 0) check("obs extra", 72'h1, 72'h0);
            else check("observed", 72'(obs), 72'(q_obs.pop_front()));
        end
    end

    initial begin
        new_req(r);
        strap_v = r.addr;
        u_bus_agent_model.strap(strap_v);
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        u_bus_agent_model.strap('0);
        repeat (4) @(posedge mclk);
        check("straps", 72'(straps), 72'(strap_v));
        for (int i = 0; i < 4; i++) begin
            new_req(r);
            issue(r, i[0], (i < 2) ? 0 : i - 1);
            drain();
        end
        mask_n <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            new_req(r);
            q_obs.push_back({1'b1, r});
            u_bus_agent_model.send(r);
            drain();
        end
        test_done();
    end
endmodule

`default_nettype wire
